// [src/lfm_pkg.sv]
// Purpose: constants and carrier types for the line format mode block
// Assumes: byte wide registers, each on one aligned 32-bit word
// Notes:   offsets are byte addresses on the register bus
package lfm_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_MODE      = 12'h1C0; // shared mode offset
  localparam logic [11:0] OFS_STATUS    = 12'h1C4; // read: channel status
  localparam logic [11:0] OFS_COMMAND   = 12'h1C8; // write: command
  localparam logic [11:0] OFS_IRQ       = 12'h1D4; // read: events, write: mask

  localparam logic [7:0]  MODE1_RESET   = 8'h00;
  localparam logic [7:0]  MODE2_RESET   = 8'h00;
  localparam logic [2:0]  MASK_RESET    = 3'h0;

  // ---------------------------------------------------------------
  // command register miscellaneous field
  // ---------------------------------------------------------------
  localparam int          CMD_MISC_LSB  = 4;
  localparam logic [2:0]  CMD_RST_PTR   = 3'h1; // reset mode pointer
  localparam logic [2:0]  CMD_RST_ERR   = 3'h4; // reset error status

  // ---------------------------------------------------------------
  // parity mode field values
  // ---------------------------------------------------------------
  localparam logic [1:0]  PM_WITH       = 2'h0;
  localparam logic [1:0]  PM_FORCE      = 2'h1;
  localparam logic [1:0]  PM_NONE       = 2'h2;
  localparam logic [1:0]  PM_MULTIDROP  = 2'h3;

  // ---------------------------------------------------------------
  // status and event bit positions
  // ---------------------------------------------------------------
  localparam int          ST_AVAIL      = 0;
  localparam int          ST_FULL       = 1;
  localparam int          ST_PARITY     = 5;
  localparam int          ST_FRAMING    = 6;
  localparam int          ST_BREAK      = 7;
  localparam int          EV_PARITY     = 0; // rx parity mismatch
  localparam int          EV_HEAD_ERR   = 1; // errored char at head
  localparam int          EV_FULL       = 2; // fifo became full
  localparam int          EV_W          = 3;

  // first mode register as stored
  typedef struct packed {
    logic       rx_flow;     // bit 7 receiver flow control enable
    logic       irq_sel;     // bit 6 irq source: 1 full, 0 available
    logic       err_block;   // bit 5 block error mode
    logic [1:0] parity_mode; // bits 4..3
    logic       parity_type; // bit 2
    logic [1:0] char_bits;   // bits 1..0, 00 = five bits
  } lfm_mode1_t;

  // error flags of the character at the fifo head
  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
  } lfm_err_t;

endpackage : lfm_pkg

// [src/lfm_mode_regs.sv]
// Purpose: first line format mode register, mode pointer, error status
// Assumes: fifo and shift logic share clock_in; Avalon-MM slave port
// Notes:   every access finishes with one wait cycle
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - the shared mode offset reaches the first mode register only while the pointer is reset, by system reset or the reset-pointer command.
// - any read or write of the first mode register moves the pointer to the second mode register.
// - with bit 7 set, request-to-send drops while the receive fifo is full and returns when room returns; with it clear the receiver leaves it alone.
// - with bit 5 clear, break, framing and parity status show only the character at the fifo head.
// - with bit 5 set, those flags are a sticky OR over every head character taken while bit 5 was set since the last reset-error-status command.
// - bits 4..3 choose parity or multidrop, and 00 is normal parity with bit 2 picking even or odd.
// - bit 2 sets the parity sense for mode 0x, and marks sent characters as address or data for mode 11.
// - with parity on, the transmitter appends the parity bit and, except in multidrop, the receiver checks and flags mismatches.
// - accesses to the second mode register leave the pointer alone.
// - bits 1..0 set the data bits per character for transmitter and receiver.
module lfm_mode_regs
  import lfm_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // register bus
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  output logic                   irq_out,
  // receive side
  input  wire logic              receive_fifo_full_flag_in,
  input  wire logic              receive_char_available_in,
  input  wire logic              head_advance_in,
  input  wire lfm_err_t          head_err_in,
  input  wire logic              rts_request_in,
  input  wire logic              rx_check_in,
  input  wire logic [7:0]        rx_char_in,
  input  wire logic              rx_parity_in,
  output logic                   rts_out,
  output logic                   rx_irq_req_out,
  output logic                   rx_parity_err_out,
  output logic                   addr_data_flag_out,
  // transmit side
  input  wire logic [7:0]        tx_char_in,
  output logic                   tx_parity_out,
  output logic                   tx_parity_en_out,
  // configuration as seen by the shift logic
  output lfm_mode1_t             mode1_out,
  output logic      [7:0]        mode2_out
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // parity of the low n data bits, n = 5 + char_bits; used on both paths
  function automatic logic parity_of(input logic [7:0] data,
                                     input lfm_mode1_t m);
    logic acc;
    acc = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 5 + int'(m.char_bits)) begin
        acc = acc ^ data[i];
      end
    end
    case (m.parity_mode)
      PM_WITH:      parity_of = acc ^ m.parity_type; // odd adds one
      PM_FORCE:     parity_of = m.parity_type;
      PM_MULTIDROP: parity_of = m.parity_type;       // address tag
      default:      parity_of = 1'b0;
    endcase
  endfunction : parity_of

  function automatic logic parity_on(input lfm_mode1_t m);
    parity_on = (m.parity_mode != PM_NONE);
  endfunction : parity_on

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  lfm_mode1_t          mode1_ff;
  logic      [7:0]     mode2_ff;
  logic                ptr_second_ff;   // 1: shared offset hits mode 2
  logic                ack_ff;
  logic      [31:0]    rdata_ff;
  lfm_err_t            sticky_ff;
  logic      [EV_W-1:0] events_ff;
  logic      [EV_W-1:0] mask_ff;
  logic                full_prev_ff;
  logic                rx_perr_ff;
  logic                tx_par_ff;
  logic                rts_ff;

  logic                accept;
  logic                wr_acc;
  logic                rd_acc;
  logic                lane0;
  logic      [7:0]     wbyte;
  logic                cmd_wr;
  logic      [2:0]     misc;
  lfm_err_t            err_view;
  logic      [7:0]     status_byte;
  logic      [EV_W-1:0] ev_set;
  logic      [31:0]    nxt_rdata;

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // one wait cycle lets read data come from a flop; side effects land
  // only on the edge the master sees waitrequest low
  assign accept              = (avs_read_in | avs_write_in) & ack_ff;
  assign wr_acc              = accept & avs_write_in;
  assign rd_acc              = accept & avs_read_in;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_ff;
  assign avs_readdata_out    = rdata_ff;
  assign lane0               = avs_byteenable_in[0];
  assign wbyte               = avs_writedata_in[7:0];
  assign cmd_wr = wr_acc & lane0 & (avs_address_in == OFS_COMMAND);
  assign misc   = wbyte[CMD_MISC_LSB +: 3];

  // ack toggles so back to back requests each get a wait cycle
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read_in | avs_write_in) & ~ack_ff;
    end
  end

  // ---------------------------------------------------------------
  // mode registers and pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      ptr_second_ff <= 1'b0;
    end else if (cmd_wr && misc == CMD_RST_PTR) begin
      ptr_second_ff <= 1'b0;
    end else if (accept && avs_address_in == OFS_MODE) begin
      ptr_second_ff <= 1'b1;
    end
  end

  // the shared offset writes whichever register the pointer names
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mode1_ff <= lfm_mode1_t'(MODE1_RESET);
      mode2_ff <= MODE2_RESET;
    end else if (wr_acc && lane0 && avs_address_in == OFS_MODE) begin
      if (!ptr_second_ff) begin
        mode1_ff <= lfm_mode1_t'(wbyte);
      end else begin
        mode2_ff <= wbyte;
      end
    end
  end

  assign mode1_out = mode1_ff;  // char_bits drive both paths
  assign mode2_out = mode2_ff;

  // ---------------------------------------------------------------
  // flow control and receiver request
  // ---------------------------------------------------------------
  // rts_request_in is the software output-port level; the receiver
  // only overrides it while flow control is on and the fifo is full
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rts_ff <= 1'b0;
    end else if (mode1_ff.rx_flow) begin
      rts_ff <= rts_request_in & ~receive_fifo_full_flag_in;
    end else begin
      rts_ff <= rts_request_in;
    end
  end
  assign rts_out = rts_ff;

  assign rx_irq_req_out = mode1_ff.irq_sel ?
                          receive_fifo_full_flag_in :
                          receive_char_available_in;

  // ---------------------------------------------------------------
  // error status
  // ---------------------------------------------------------------
  // sticky flags: a head arrival in the clear cycle still sets
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      sticky_ff <= '0;
    end else begin
      sticky_ff <= ((cmd_wr && misc == CMD_RST_ERR) ? '0 : sticky_ff)
                   | ((head_advance_in && mode1_ff.err_block) ?
                      head_err_in : '0);
    end
  end

  // character mode shows the head only; multidrop expects this
  assign err_view = mode1_ff.err_block ? sticky_ff :
                    (receive_char_available_in ? head_err_in
                                               : '0);

  always_comb begin
    status_byte              = 8'h00;
    status_byte[ST_AVAIL]    = receive_char_available_in;
    status_byte[ST_FULL]     = receive_fifo_full_flag_in;
    status_byte[ST_PARITY]   = err_view.parity;
    status_byte[ST_FRAMING]  = err_view.framing;
    status_byte[ST_BREAK]    = err_view.brk;
  end

  // ---------------------------------------------------------------
  // parity paths
  // ---------------------------------------------------------------
  assign tx_parity_en_out = parity_on(mode1_ff);

  // transmit bit follows the character presented by the shifter
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      tx_par_ff <= 1'b0;
    end else begin
      tx_par_ff <= parity_of(tx_char_in, mode1_ff);
    end
  end
  assign tx_parity_out = tx_par_ff;

  // receive check: one-cycle flag per checked character
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_perr_ff <= 1'b0;
    end else begin
      rx_perr_ff <= rx_check_in && parity_on(mode1_ff)
                    && mode1_ff.parity_mode != PM_MULTIDROP
                    && rx_parity_in != parity_of(rx_char_in,
                                                 mode1_ff);
    end
  end
  assign rx_parity_err_out = rx_perr_ff;

  // in multidrop the received ninth bit is the address/data flag
  assign addr_data_flag_out = (mode1_ff.parity_mode == PM_MULTIDROP)
                              & rx_parity_in;

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      full_prev_ff <= 1'b0;
    end else begin
      full_prev_ff <= receive_fifo_full_flag_in;
    end
  end

  always_comb begin
    ev_set              = '0;
    ev_set[EV_PARITY]   = rx_perr_ff;
    ev_set[EV_HEAD_ERR] = head_advance_in & (|head_err_in);
    ev_set[EV_FULL]     = receive_fifo_full_flag_in & ~full_prev_ff;
  end

  // a read clears only bits it returned, so nothing set since is lost
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      events_ff <= '0;
    end else if (rd_acc && avs_address_in == OFS_IRQ) begin
      events_ff <= (events_ff & ~rdata_ff[EV_W-1:0]) | ev_set;
    end else begin
      events_ff <= events_ff | ev_set;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      mask_ff <= MASK_RESET;
    end else if (wr_acc && lane0 && avs_address_in == OFS_IRQ) begin
      mask_ff <= wbyte[EV_W-1:0];
    end
  end

  assign irq_out = |(events_ff & mask_ff);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // unmapped offsets and write-only registers read as zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_in)
      OFS_MODE:   nxt_rdata[7:0] = ptr_second_ff ? mode2_ff
                                                 : 8'(mode1_ff);
      OFS_STATUS: nxt_rdata[7:0] = status_byte;
      OFS_IRQ:    nxt_rdata[EV_W-1:0] = events_ff;
      default:    nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read_in && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  a_ptr_advance: assert property (accept && avs_address_in == OFS_MODE
      && !(cmd_wr) |=> ptr_second_ff)
    else $error("pointer did not advance after mode access");
  a_ptr_reset: assert property (cmd_wr && misc == CMD_RST_PTR
      |=> !ptr_second_ff)
    else $error("pointer not reset by command");
  a_ptr_hold: assert property (ptr_second_ff && !(cmd_wr
      && misc == CMD_RST_PTR) |=> ptr_second_ff)
    else $error("pointer left second register");
  a_mode1_write: assert property (wr_acc && lane0 && !ptr_second_ff
      && avs_address_in == OFS_MODE
      |=> 8'(mode1_ff) == $past(wbyte))
    else $error("first mode register not written");
  a_rts_full: assert property (mode1_ff.rx_flow
      && receive_fifo_full_flag_in ##1 mode1_ff.rx_flow
      |-> !rts_out)
    else $error("rts asserted while fifo full");
  a_irq_source: assert property (rx_irq_req_out == (mode1_ff.irq_sel ?
      receive_fifo_full_flag_in : receive_char_available_in))
    else $error("receiver request from wrong source");
  a_char_mode: assert property (!mode1_ff.err_block
      && receive_char_available_in
      |-> status_byte[ST_PARITY] == head_err_in.parity)
    else $error("character mode parity status wrong");
  a_block_sticky: assert property (mode1_ff.err_block && head_advance_in
      && head_err_in.framing |=> sticky_ff.framing)
    else $error("block mode framing flag not held");
  a_parity_type: assert property (mode1_ff.parity_mode == PM_FORCE
      |=> tx_parity_out == $past(mode1_ff.parity_type))
    else $error("forced parity bit wrong");
  a_rx_check: assert property (rx_check_in
      && mode1_ff.parity_mode == PM_NONE |=> !rx_parity_err_out)
    else $error("parity flagged with parity off");
  a_bus_wait: assert property ((avs_read_in || avs_write_in) && !ack_ff
      |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("access not answered after one wait cycle");

  c_ptr_cycle: cover property (accept && avs_address_in == OFS_MODE
      ##[1:40] cmd_wr && misc == CMD_RST_PTR);
  c_rts_drop: cover property (mode1_ff.rx_flow && rts_out ##1 !rts_out);
  c_parity_err: cover property (rx_parity_err_out ##[1:5] irq_out);
  c_block_err: cover property (mode1_ff.err_block && |sticky_ff);

endmodule : lfm_mode_regs

`default_nettype wire

// [dv/lfm_rx_model.sv]
// Purpose: far-end stand-in that hands received characters to the block
// Assumes: one character per send pulse, parity from the live mode
// Notes:   idle character and parity lines keep toggling so a stale value never passes
`timescale 1ns/100ps
`default_nettype none
module lfm_rx_model
  import lfm_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       send_in,
  input  wire logic       bad_in,
  input  wire logic [7:0] char_in,
  input  wire lfm_err_t   err_in,
  input  wire lfm_mode1_t mode_in,
  output logic            rx_check_out,
  output logic            head_adv_out,
  output logic [7:0]      rx_char_out,
  output logic            rx_parity_out,
  output lfm_err_t        head_err_out
);
  // line parity for a mode, masked to the character length
  function automatic logic par_of(input lfm_mode1_t m, input logic [7:0] c);
    logic [7:0] k;
    k = c & (8'hFF >> (2'h3 - m.char_bits));
    case (m.parity_mode)
      PM_WITH: par_of = m.parity_type ? ~^k : ^k;
      PM_NONE: par_of = 1'h0;
      default: par_of = m.parity_type;
    endcase
  endfunction : par_of

  // one strobe per character; bad_in flips parity on purpose
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      rx_check_out  <= 1'h0;
      head_adv_out  <= 1'h0;
      rx_char_out   <= 8'h00;
      rx_parity_out <= 1'h0;
      head_err_out  <= 3'h0;
    end else begin
      rx_check_out <= send_in;
      head_adv_out <= send_in;
      if (send_in) begin
        rx_char_out   <= char_in;
        rx_parity_out <= par_of(mode_in, char_in) ^ bad_in;
        head_err_out  <= err_in; // head errors stand until next char
      end else begin
        rx_char_out   <= ~rx_char_out;
        rx_parity_out <= ~rx_parity_out;
      end
    end
  end
endmodule : lfm_rx_model
`default_nettype wire

// [dv/lfm_mode_regs_tb_top.sv]
// Purpose: self-checking bench of the line format mode registers
// Assumes: lfm_rx_model stands in for the receive path
// Notes:   waitrequest and read data are sampled at the rising edge only
`timescale 1ns/100ps
`default_nettype none
module lfm_mode_regs_tb_top
  import lfm_pkg::*;
();
  logic             clock_in, rst_in, rd, wr, full, avail, rts_req;
  logic             send, bad, wreq, irq, rts, rxirq, perr, adf, txp, txen;
  logic             chk_, rxp, rxc, hadv;
  logic [11:0]      addr;
  logic [31:0]      wdata, rdata;
  logic [7:0]       q, v1, v2, v3, d, txc, rxd, rxq, m2;
  lfm_err_t         err, herr;
  lfm_mode1_t       m1;
  int               err_total = 0;
  int               num_checks = 0;
  int               seed = 33762;
  int               cyc = 0;

  lfm_mode_regs DUT (.clock_in(clock_in), .rst_in(rst_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .irq_out(irq),
    .receive_fifo_full_flag_in(full), .receive_char_available_in(avail),
    .head_advance_in(hadv), .head_err_in(herr), .rts_request_in(rts_req),
    .rx_check_in(rxc), .rx_char_in(rxq), .rx_parity_in(rxp),
    .rts_out(rts), .rx_irq_req_out(rxirq), .rx_parity_err_out(perr),
    .addr_data_flag_out(adf), .tx_char_in(txc), .tx_parity_out(txp),
    .tx_parity_en_out(txen), .mode1_out(m1), .mode2_out(m2));

  lfm_rx_model RX (.clock_in(clock_in), .rst_in(rst_in), .send_in(send),
    .bad_in(bad), .char_in(rxd), .err_in(err), .mode_in(m1),
    .rx_check_out(rxc), .head_adv_out(hadv), .rx_char_out(rxq),
    .rx_parity_out(rxp), .head_err_out(herr));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [7:0] dv, output logic [7:0] rq);
    @(posedge clock_in);
    rd    <= ~w;
    wr    <= w;
    addr  <= a;
    wdata <= {24'h0, dv};
    do @(posedge clock_in); while (wreq !== 1'h0);
    rq = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : bus

  task automatic wr8(input logic [11:0] a, input logic [7:0] dv);
    logic [7:0] x;
    bus(1'h1, a, dv, x);
  endtask : wr8

  // pointer back to the first register first, so every write lands there
  task automatic set1(input logic [7:0] dv);
    wr8(OFS_COMMAND, {1'h0, CMD_RST_PTR, 4'h0});
    wr8(OFS_MODE, dv);
  endtask : set1

  task automatic rx(input logic [7:0] dv, input logic b, input lfm_err_t e);
    @(posedge clock_in);
    send <= 1'h1;
    rxd  <= dv;
    bad  <= b;
    err  <= e;
    @(posedge clock_in);
    send <= 1'h0;
  endtask : rx

  task automatic step;
    repeat (2) @(posedge clock_in);
    @(negedge clock_in);
  endtask : step

  task automatic complete_run;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run

  initial begin
    clock_in = 1'h0;
    forever #25 clock_in = ~clock_in;
  end

  // a hang is cut short well above the few hundred cycles needed
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_in, rd, wr, full, avail, rts_req, send, bad} = 8'h80;
    {addr, wdata, txc, rxd, err} = '0;
    repeat (10) @(posedge clock_in);
    rst_in <= 1'h0;
    v1 = $random(seed);
    v2 = $random(seed);
    v3 = $random(seed);
    bus(1'h0, OFS_MODE, 8'h00, q);
    chk(q, MODE1_RESET);
    wr8(OFS_MODE, v2);
    @(negedge clock_in);
    chk({m1, m2}, {MODE1_RESET, v2});
    wr8(OFS_MODE, v3);
    @(negedge clock_in);
    chk(m2, v3);
    set1(v1);
    @(negedge clock_in);
    chk(m1, v1);
    bus(1'h0, OFS_MODE, 8'h00, q);
    chk(q, v3);
    wr8(OFS_COMMAND, 8'h10);
    bus(1'h0, OFS_MODE, 8'h00, q);
    chk(q, v1);
    bus(1'h0, 12'h1DC, 8'h00, q); // unmapped, away from test offsets
    chk(q, 8'h00);
    // flow control on, then off with a random software level
    rts_req <= 1'h1;
    set1(8'h80);
    full <= 1'h1;
    step();
    chk(rts, 1'h0);
    full <= 1'h0;
    step();
    chk(rts, 1'h1);
    d = $random(seed);
    set1(8'h00);
    full    <= 1'h1;
    rts_req <= d[0];
    step();
    chk(rts, d[0]);
    for (int s = 0; s < 8; s++) begin
      if (s[1:0] == 2'h0) set1({1'h0, s[2], 6'h0});
      @(posedge clock_in);
      full  <= s[0];
      avail <= s[1];
      @(negedge clock_in);
      chk(rxirq, s[2] ? s[0] : s[1]);
    end
    // head errors: character mode, then sticky block mode
    @(posedge clock_in);
    full  <= 1'h0;
    avail <= 1'h1;
    set1(8'h00);
    rx(8'h11, 1'h0, 3'h5);
    rx(8'h12, 1'h0, 3'h2);
    step();
    bus(1'h0, OFS_STATUS, 8'h00, q);
    chk(q, 8'h41);
    set1(8'h20);
    wr8(OFS_COMMAND, {1'h0, CMD_RST_ERR, 4'h0});
    rx(8'h13, 1'h0, 3'h4);
    rx(8'h14, 1'h0, 3'h1);
    step();
    bus(1'h0, OFS_STATUS, 8'h00, q);
    chk(q, 8'hA1);
    wr8(OFS_COMMAND, {1'h0, CMD_RST_ERR, 4'h0});
    bus(1'h0, OFS_STATUS, 8'h00, q);
    chk(q, 8'h01);
    // every parity mode and sense, random lengths and characters
    for (int i = 0; i < 16; i++) begin
      d  = $random(seed);
      v1 = $random(seed);
      v1[7:2] = {3'h0, i[1:0], i[2]}; // block mode off in multidrop
      set1(v1);
      txc <= d;
      @(posedge clock_in);
      @(negedge clock_in);
      chk(txp, RX.par_of(v1, d));
      chk(txen, i[1:0] != PM_NONE);
      rx(d, i[3], 3'h0);
      @(negedge clock_in);
      if (i[1:0] == PM_MULTIDROP) chk(adf, i[2] ^ i[3]);
      @(posedge clock_in);
      @(negedge clock_in);
      chk(perr, i[1] == 1'h0 && i[3]);
      step();
    end
    // interrupt raised, read back, cleared, then masked
    set1(8'h00);
    wr8(OFS_IRQ, 8'h01);
    bus(1'h0, OFS_IRQ, 8'h00, q);
    rx(8'h3C, 1'h1, 3'h0);
    step();
    chk(irq, 1'h1);
    bus(1'h0, OFS_IRQ, 8'h00, q);
    chk(q, 8'h01);
    @(negedge clock_in);
    chk(irq, 1'h0);
    wr8(OFS_IRQ, 8'h00);
    rx(8'h3C, 1'h1, 3'h0);
    step();
    chk(irq, 1'h0);
    complete_run();
  end
endmodule : lfm_mode_regs_tb_top
`default_nettype wire
